/* include/isdf_defines.svh */
// Register indices, field positions and reset values of the I2C slave data block.
`ifndef ISDF_DEFINES_SVH
`define ISDF_DEFINES_SVH

`define ISDF_IDX_IRQ_STAT   8'hE0
`define ISDF_IDX_ADDR       8'hE9
`define ISDF_IDX_CTRL       8'hEA
`define ISDF_IDX_FIRST_RX   8'hEB
`define ISDF_IDX_TX_RX2     8'hEC

`define ISDF_BIT_TX_DONE    2
`define ISDF_BIT_RX2        1
`define ISDF_BIT_RX1        0
`define ISDF_EN_LSB         4
`define ISDF_ADDR_LSB       1
`define ISDF_ADDR_EN_BIT    0

`define ISDF_RST_FLAGS      3'h4
`define ISDF_RST_EN         3'h0
`define ISDF_RST_IRQ        3'h0
`define ISDF_RST_ADDR       8'h64
`define ISDF_RST_BYTE       8'h00
`define ISDF_LAST_BIT       3'h7

`endif

/* include/isdf_pkg.sv */
// Types shared by the I2C slave data block.
package isdf_pkg;
  typedef enum logic [2:0] {
    ISDF_IDLE = 3'h0,
    ISDF_ADDR = 3'h1,
    ISDF_AACK = 3'h3,
    ISDF_RX   = 3'h2,
    ISDF_RACK = 3'h6,
    ISDF_TX   = 3'h7,
    ISDF_TACK = 3'h5
  } isdf_state_t;
endpackage

/* verilog/isdf_top.sv */
// I2C slave data path: receive and transmit byte registers, completion flags and Wishbone registers.
// Functional notes
// - Finishing a byte sent to the master sets the transmit-done flag, which resets to 1 and clears on a write of 0.
// - Filling the second receive byte sets the second-byte flag, which resets to 0 and clears only on a write of 0.
// - Filling the first receive byte sets the first-byte flag, which resets to 0 and clears on a write of 0.
// - The first received byte is readable by software and writes to it change nothing.
// - A read of the shared data register returns the second received byte.
// - A write of the shared data register loads the next byte to send and leaves the read value alone.
// - Each completion event sets a sticky status bit, which raises an interrupt only while its enable bit is 1.
`timescale 1ns/100ps
`include "isdf_defines.svh"

module isdf_top (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [9:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ,
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE
);
  import isdf_pkg::*;

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic                    ack_q;
  logic [31:0]             rdat_q;
  logic                    acc;
  logic                    wr_acc;
  logic                    rd_acc;

  function automatic logic hit(input logic [9:0] adr, input logic [7:0] index);
    hit = (adr == {index, 2'b00});
  endfunction
  assign acc    = WB_CYC_I && WB_STB_I && ack_q;
  assign wr_acc = acc && WB_WE_I && WB_SEL_I[0];
  assign rd_acc = acc && !WB_WE_I;
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign SDA_O    = 1'b0;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0]              flags_q;
  logic [2:0]              en_q;
  logic [2:0]              irq_q;
  logic [7:0]              addr_q;
  logic [7:0]              first_q;
  logic [7:0]              second_q;
  logic [7:0]              tx_q;
  logic [2:0]              ev;
  logic [7:0]              rx_byte;
  logic                    ctrl_wr;
  logic [2:0]              flags_d;

  assign ctrl_wr = wr_acc && hit(WB_ADR_I, `ISDF_IDX_CTRL);
  always_comb begin
    flags_d = flags_q;
    if (ctrl_wr) begin
      flags_d = flags_q & WB_DAT_I[2:0];
    end
    flags_d = flags_d | ev;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      flags_q <= `ISDF_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      en_q   <= `ISDF_RST_EN;
      addr_q <= `ISDF_RST_ADDR;
    end else begin
      if (ctrl_wr) begin
        en_q <= WB_DAT_I[`ISDF_EN_LSB +: 3];
      end
      if (wr_acc && hit(WB_ADR_I, `ISDF_IDX_ADDR)) begin
        addr_q <= WB_DAT_I[7:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tx_q <= `ISDF_RST_BYTE;
    end else if (wr_acc && hit(WB_ADR_I, `ISDF_IDX_TX_RX2)) begin
      tx_q <= WB_DAT_I[7:0];
    end
  end
  // Sticky status; a read clears only the bits it returned, so a later event waits for the next read.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_q <= `ISDF_RST_IRQ;
    end else begin
      irq_q <= (irq_q & ~((rd_acc && hit(WB_ADR_I, `ISDF_IDX_IRQ_STAT)) ? rdat_q[2:0] : 3'h0)) | ev;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_q & en_q);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      rdat_q <= 32'h0000_0000;
      if (WB_CYC_I && WB_STB_I && !ack_q && !WB_WE_I) begin
        if (hit(WB_ADR_I, `ISDF_IDX_IRQ_STAT)) begin
          rdat_q[2:0] <= irq_q;
        end else if (hit(WB_ADR_I, `ISDF_IDX_ADDR)) begin
          rdat_q[7:0] <= addr_q;
        end else if (hit(WB_ADR_I, `ISDF_IDX_CTRL)) begin
          rdat_q[7:0] <= {1'b0, en_q, 1'b0, flags_q};
        end else if (hit(WB_ADR_I, `ISDF_IDX_FIRST_RX)) begin
          rdat_q[7:0] <= first_q;
        end else if (hit(WB_ADR_I, `ISDF_IDX_TX_RX2)) begin
          rdat_q[7:0] <= second_q;
        end
      end
    end
  end

  // ****************************************
  // Link sampling
  // ****************************************
  logic [1:0]              scl_s;
  logic [1:0]              sda_s;
  logic                    scl_p;
  logic                    sda_p;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_c;
  logic                    stop_c;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], SCL_I};
      sda_s <= {sda_s[0], SDA_I};
      scl_p <= scl_s[1];
      sda_p <= sda_s[1];
    end
  end

  assign scl_rise = scl_s[1] && !scl_p;
  assign scl_fall = !scl_s[1] && scl_p;
  assign start_c  = scl_s[1] && scl_p && sda_p && !sda_s[1];
  assign stop_c   = scl_s[1] && scl_p && !sda_p && sda_s[1];

  // ****************************************
  // Byte engine
  // ****************************************
  isdf_state_t             st_q;
  logic [2:0]              cnt_q;
  logic [7:0]              sh_q;
  logic                    rw_q;
  logic                    phase_q;
  logic                    second_next_q;
  logic                    nack_q;

  assign rx_byte = {sh_q[6:0], sda_s[1]};
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_q          <= ISDF_IDLE;
      cnt_q         <= 3'h0;
      sh_q          <= 8'h00;
      rw_q          <= 1'b0;
      phase_q       <= 1'b0;
      second_next_q <= 1'b0;
      nack_q        <= 1'b0;
      SDA_OE        <= 1'b0;
    end else if (!addr_q[`ISDF_ADDR_EN_BIT] || stop_c) begin
      st_q   <= ISDF_IDLE;
      SDA_OE <= 1'b0;
    end else if (start_c) begin
      st_q          <= ISDF_ADDR;
      cnt_q         <= 3'h0;
      phase_q       <= 1'b0;
      second_next_q <= 1'b0;
      SDA_OE        <= 1'b0;
    end else begin
      case (st_q)
        ISDF_ADDR: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `ISDF_LAST_BIT) begin
              rw_q <= sda_s[1];
              st_q <= (sh_q[6:0] == addr_q[7:`ISDF_ADDR_LSB]) ? ISDF_AACK : ISDF_IDLE;
            end
          end
        end
        ISDF_AACK, ISDF_RACK: begin
          // The ack bit spans one full low-high-low period of the clock.
          if (scl_fall) begin
            phase_q <= !phase_q;
            if (!phase_q) begin
              SDA_OE <= 1'b1;
            end else if (rw_q) begin
              st_q   <= ISDF_TX;
              sh_q   <= tx_q;
              SDA_OE <= !tx_q[7];
            end else begin
              st_q   <= ISDF_RX;
              SDA_OE <= 1'b0;
            end
          end
        end
        ISDF_RX: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `ISDF_LAST_BIT) begin
              st_q          <= ISDF_RACK;
              second_next_q <= !second_next_q;
            end
          end
        end
        ISDF_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `ISDF_LAST_BIT) begin
              st_q    <= ISDF_TACK;
              phase_q <= 1'b0;
            end
          end else if (scl_fall) begin
            sh_q   <= {sh_q[6:0], 1'b0};
            SDA_OE <= !sh_q[6];
          end
        end
        ISDF_TACK: begin
          if (scl_fall && !phase_q) begin
            phase_q <= 1'b1;
            SDA_OE  <= 1'b0;
          end else if (scl_rise && phase_q) begin
            nack_q <= sda_s[1];
          end else if (scl_fall && phase_q) begin
            phase_q <= 1'b0;
            if (nack_q) begin
              st_q <= ISDF_IDLE;
            end else begin
              st_q   <= ISDF_TX;
              sh_q   <= tx_q;
              SDA_OE <= !tx_q[7];
            end
          end
        end
        default: begin
          st_q   <= ISDF_IDLE;
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end
  always_comb begin
    ev = 3'h0;
    if (!stop_c && !start_c && addr_q[`ISDF_ADDR_EN_BIT] && scl_rise && cnt_q == `ISDF_LAST_BIT) begin
      ev[`ISDF_BIT_TX_DONE] = (st_q == ISDF_TX);
      ev[`ISDF_BIT_RX2]     = (st_q == ISDF_RX) && second_next_q;
      ev[`ISDF_BIT_RX1]     = (st_q == ISDF_RX) && !second_next_q;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      first_q  <= `ISDF_RST_BYTE;
      second_q <= `ISDF_RST_BYTE;
    end else begin
      if (ev[`ISDF_BIT_RX1]) begin
        first_q <= rx_byte;
      end
      if (ev[`ISDF_BIT_RX2]) begin
        second_q <= rx_byte;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  property p_tx_set;
    ev[`ISDF_BIT_TX_DONE] |=> flags_q[`ISDF_BIT_TX_DONE] ##1 flags_q[`ISDF_BIT_TX_DONE] || $past(ctrl_wr);
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx done flag not set");
  property p_rx2_clr;
    ctrl_wr && !WB_DAT_I[`ISDF_BIT_RX2] && !ev[`ISDF_BIT_RX2] |=> !flags_q[`ISDF_BIT_RX2];
  endproperty
  a_rx2_clr: assert property (p_rx2_clr) else $error("second byte flag not cleared");
  property p_rx2_hold;
    flags_q[`ISDF_BIT_RX2] && !ctrl_wr |=> flags_q[`ISDF_BIT_RX2];
  endproperty
  a_rx2_hold: assert property (p_rx2_hold) else $error("second byte flag lost");
  property p_rx1_set;
    ev[`ISDF_BIT_RX1] |=> flags_q[`ISDF_BIT_RX1] && first_q == $past(rx_byte);
  endproperty
  a_rx1_set: assert property (p_rx1_set) else $error("first byte flag or data wrong");
  property p_first_ro;
    wr_acc && hit(WB_ADR_I, `ISDF_IDX_FIRST_RX) && !ev[`ISDF_BIT_RX1] |=> $stable(first_q);
  endproperty
  a_first_ro: assert property (p_first_ro) else $error("first byte changed by write");
  property p_read2;
    WB_CYC_I && WB_STB_I && !ack_q && !WB_WE_I && hit(WB_ADR_I, `ISDF_IDX_TX_RX2)
      |=> ack_q && WB_DAT_O[7:0] == $past(second_q);
  endproperty
  a_read2: assert property (p_read2) else $error("shared read not second byte");
  property p_tx_write;
    wr_acc && hit(WB_ADR_I, `ISDF_IDX_TX_RX2) && !ev[`ISDF_BIT_RX2]
      |=> tx_q == $past(WB_DAT_I[7:0]) && $stable(second_q);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit byte load wrong");
  property p_irq_mask;
    en_q == 3'h0 ##1 en_q == 3'h0 |-> !IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while disabled");
  property p_byte_first;
    $rose(flags_q[`ISDF_BIT_RX2]) |-> second_q == $past(rx_byte);
  endproperty
  a_byte_first: assert property (p_byte_first) else $error("second byte late");
  property p_ack_pulse;
    ack_q |=> !ack_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  c_tx_done: cover property (ev[`ISDF_BIT_TX_DONE]);
  c_rx1: cover property (ev[`ISDF_BIT_RX1] ##[1:1000] ev[`ISDF_BIT_RX2]);
  c_irq: cover property ($rose(IRQ));
endmodule

/* tb/isdf_i2c_master.sv */
// Behavioural I2C bus master that drives the slave's link pins.
`timescale 1ns/100ps

module isdf_i2c_master (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_d,
  input  wire logic sda
);
  // ****************************************
  // Line idle state
  // ****************************************
  // The clock stands high between frames, and a released data line floats to the pull-up.
  initial begin
    scl = 1'b1;
    sda_d = 1'b1;
  end

  // ****************************************
  // Bit and frame tasks
  // ****************************************
  // The data line moves well after the clock falls, so the slave never sees it change while the clock is high.
  task automatic bit_cycle(input logic v, output logic s);
    #20 sda_d = v;
    #60 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask

  // A frame begins just after a core clock edge; every later line change then falls between edges.
  task automatic start;
    @(posedge clk);
    #42 sda_d = 1'b0;
    #40 scl = 1'b0;
  endtask

  task automatic stop;
    #20 sda_d = 1'b0;
    #60 scl = 1'b1;
    #40 sda_d = 1'b1;
    #40;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(b[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, b[i]);
    end
    bit_cycle(last, s);
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the I2C slave data block.
`timescale 1ns/100ps

module tb;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [9:0]  adr      = 10'h000;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        sda_oe;
  logic        m_scl;
  logic        m_sda;
  logic        sda_w;
  logic [6:0]  a;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  t;
  logic [7:0]  r;
  logic        k;
  logic [31:0] exp_q[$];
  int          errors = 0;
  int          check_count = 0;

  always #4 core_clk = ~core_clk;
  // Open-drain data line with a pull-up: low when either party pulls it.
  assign sda_w = m_sda & ~sda_oe;

  isdf_top uut (.CORE_CLK(core_clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq),
    .SCL_I(m_scl), .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe));
  isdf_i2c_master m (.clk(core_clk), .scl(m_scl), .sda_d(m_sda), .sda(sda_w));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The interrupt line is judged half a cycle after an edge, once it has settled.
  task automatic chk_irq(input logic e);
    @(negedge core_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(idx, 1'b0, 8'h00);
  endtask

  // Read data is judged in the acknowledge cycle against the oldest note.
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk($sformatf("reg %h", adr[9:2]), exp_q.pop_front(), rdat);
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h164E));
    a = 7'h10 + 7'($urandom % 64);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    t = 8'($urandom);
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'hEA, 8'h04);
    rd(8'hE9, 8'h64);
    chk_irq(1'b0);
    wr(8'hE9, {a, 1'b1});
    rd(8'hE9, {a, 1'b1});
    wr(8'hEA, 8'h70);
    rd(8'hEA, 8'h70);
    m.start();
    m.wbyte({a ^ 7'h01, 1'b0}, k);
    m.stop();
    chk("foreign address ack", 32'h0, 32'(k));
    m.start();
    m.wbyte({a, 1'b0}, k);
    chk("address ack", 32'h1, 32'(k));
    m.wbyte(b1, k);
    chk("data ack", 32'h1, 32'(k));
    m.wbyte(b2, k);
    chk("data ack", 32'h1, 32'(k));
    m.stop();
    rd(8'hEA, 8'h73);
    chk_irq(1'b1);
    rd(8'hEB, b1);
    rd(8'hEC, b2);
    rd(8'hE0, 8'h03);
    rd(8'hE0, 8'h00);
    chk_irq(1'b0);
    wr(8'hEB, ~b1);
    rd(8'hEB, b1);
    wr(8'hEC, t);
    rd(8'hEC, b2);
    wr(8'hEA, 8'h70);
    m.start();
    m.wbyte({a, 1'b1}, k);
    m.rbyte(1'b1, r);
    m.stop();
    chk("sent byte", {24'h0, t}, {24'h0, r});
    rd(8'hEA, 8'h74);
    chk_irq(1'b1);
    rd(8'hE0, 8'h04);
    wr(8'hEA, 8'h00);
    m.start();
    m.wbyte({a, 1'b0}, k);
    m.wbyte(b2, k);
    m.stop();
    rd(8'hEA, 8'h01);
    chk_irq(1'b0);
    rd(8'hEB, b2);
    rd(8'h80, 8'h00);
    wr(8'hEA, 8'h10);
    repeat (2) @(posedge core_clk);
    chk_irq(1'b1);
    results();
  end
endmodule
